// file: mmap_ctrl.sv
// Memory map control top: Wishbone register bank plus address decode
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1 - The block has no pins; every port joins other on-chip logic.
// R2 - Resource selection decodes the core address together with the operating mode.
// R3 - Active-low external select asserts for accesses in external space.
// R4 - Active-low emulation select serves flash-space accesses made in emulation modes.
// R5 - RAM position locks after first write except in special modes.
// R6 - A new RAM position steers decoding from the cycle after the write.
// R7 - Register bits 7 to 3 give RAM base address bits 15 to 11.
// R8 - Alignment bit clear puts RAM at the bottom of its window.
// R9 - Alignment bit set puts RAM at the top of its window.
// R10 - Unimplemented register bits read zero and ignore writes.
module mmap_ctrl
  import mmap_pkg::*;
#(
  parameter int RAM_LOG2 = 10,
  parameter int REG_LOG2 = 10,
  parameter int EE_LOG2 = 10,
  parameter logic [7:0] SIZE_LO_VAL = 8'h00,
  parameter logic [7:0] SIZE_HI_VAL = 8'h00
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire mmap_mode_t mode_i,
  input wire mmap_core_req_t core_req_i,
  output mmap_sel_t sel_o,
  output logic external_chip_select_n_o,
  output logic emulation_chip_select_n_o,
  output logic [1:0] stretch_o,
  output logic [19:0] page_addr_o
);

  localparam int ONCE_N = 3;
  localparam int ONCE_RAM = 0;
  localparam int ONCE_REG = 1;
  localparam int ONCE_AUX = 2;
  localparam logic [7:0] ONCE_OFF [ONCE_N] = '{MMAP_RAM_POS_OFF, MMAP_REG_POS_OFF, MMAP_AUX_OFF};
  localparam logic [7:0] ONCE_MASK [ONCE_N] = '{MMAP_RAM_MASK, MMAP_REG_MASK, MMAP_AUX_MASK};

  // Address match, shared by the write strobes and the read mux
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction : reg_hit

  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic req_new, wr_fire, special;
  logic [7:0] rd_byte;
  logic [7:0] once_rst [ONCE_N];
  logic [7:0] once_q [ONCE_N];
  logic once_wr [ONCE_N];
  logic once_lock [ONCE_N];
  logic [7:0] ee_r, ee_nxt;
  logic [7:0] page_r, page_nxt;
  logic [7:0] ram_pos, reg_pos, aux;

  // Mode is steady after reset, so it needs no sampling here
  assign special = mmap_is_special(mode_i);

  // A request is new while no ack is pending for it
  assign req_new = wb_cyc_i && wb_stb_i && !ack_r;

  // Writes take effect at the edge where the master sees ack; lane 0 only
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0];

  // Read mux; unmapped offsets and unimplemented bits answer zero
  always_comb begin
    rd_byte = 8'h00;
    if (reg_hit(wb_adr_i, MMAP_RAM_POS_OFF)) begin
      rd_byte = ram_pos & MMAP_RAM_MASK; // see R10
    end else if (reg_hit(wb_adr_i, MMAP_REG_POS_OFF)) begin
      rd_byte = reg_pos & MMAP_REG_MASK; // see R10
    end else if (reg_hit(wb_adr_i, MMAP_EE_POS_OFF)) begin
      rd_byte = ee_r & MMAP_EE_MASK;
    end else if (reg_hit(wb_adr_i, MMAP_AUX_OFF)) begin
      rd_byte = aux & MMAP_AUX_MASK;
    end else if (reg_hit(wb_adr_i, MMAP_TEST0_OFF)) begin
      rd_byte = 8'h00;
    end else if (reg_hit(wb_adr_i, MMAP_SIZE_LO_OFF)) begin
      rd_byte = SIZE_LO_VAL;
    end else if (reg_hit(wb_adr_i, MMAP_SIZE_HI_OFF)) begin
      rd_byte = SIZE_HI_VAL;
    end else if (reg_hit(wb_adr_i, MMAP_PAGE_OFF)) begin
      rd_byte = page_r & MMAP_PAGE_MASK;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_nxt = req_new;
    dat_nxt = req_new ? {24'h000000, rd_byte} : 32'h00000000;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Reset values of the lockable registers; test mode boots with flash off
  always_comb begin
    once_rst[ONCE_RAM] = MMAP_RAM_RST;
    once_rst[ONCE_REG] = MMAP_REG_RST;
    once_rst[ONCE_AUX] = (mode_i == MMAP_SPECIAL_TEST) ? MMAP_AUX_RST_TEST : MMAP_AUX_RST;
  end

  // Lockable mapping registers each get their own write-once cell
  generate
    for (genvar g = 0; g < ONCE_N; g++) begin : g_once
      assign once_wr[g] = wr_fire && reg_hit(wb_adr_i, ONCE_OFF[g]);
      mmap_once_reg #(
        .MASK(ONCE_MASK[g])
      ) u_once (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rst_val_i(once_rst[g]),
        .wr_i(once_wr[g]),
        .special_i(special), // see R5
        .dat_i(wb_dat_i[7:0]),
        .q_o(once_q[g]),
        .locked_o(once_lock[g])
      );
    end
  endgenerate

  assign ram_pos = once_q[ONCE_RAM];
  assign reg_pos = once_q[ONCE_REG];
  assign aux = once_q[ONCE_AUX];

  // EEPROM position and page index stay writable at any time
  always_comb begin
    ee_nxt = ee_r;
    page_nxt = page_r;
    if (wr_fire && reg_hit(wb_adr_i, MMAP_EE_POS_OFF)) begin
      ee_nxt = wb_dat_i[7:0] & MMAP_EE_MASK; // see R10
    end
    if (wr_fire && reg_hit(wb_adr_i, MMAP_PAGE_OFF)) begin
      page_nxt = wb_dat_i[7:0] & MMAP_PAGE_MASK; // see R10
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ee_r <= MMAP_EE_RST;
      page_r <= MMAP_PAGE_RST;
    end else begin
      ee_r <= ee_nxt;
      page_r <= page_nxt;
    end
  end

  // Decoder reads only registered positions, so a write counts a cycle later
  mmap_decode #(
    .RAM_LOG2(RAM_LOG2),
    .REG_LOG2(REG_LOG2),
    .EE_LOG2(EE_LOG2)
  ) u_decode (
    .req_i(core_req_i), // see R1
    .mode_i(mode_i), // see R2
    .ram_pos_i(ram_pos), // see R6
    .reg_pos_i(reg_pos),
    .ee_pos_i(ee_r),
    .aux_i(aux),
    .page_i(page_r),
    .sel_o(sel_o),
    .xcs_n_o(external_chip_select_n_o),
    .ecs_n_o(emulation_chip_select_n_o),
    .page_addr_o(page_addr_o)
  );

  // Stretch count only matters for external accesses
  assign stretch_o = aux[MMAP_AUX_STRETCH_LSB +: 2];

  // Checks on bus timing and mapping behaviour
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_locked_ram_write;
    once_wr[ONCE_RAM] && !special && once_lock[ONCE_RAM];
  endsequence

  sequence s_special_ram_write;
    once_wr[ONCE_RAM] && special;
  endsequence

  // Ack comes exactly one cycle after a new request and lasts one cycle
  bus_ack_timing_a: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o) // see R2
    else $error("wishbone ack not one cycle after request");

  // A locked RAM position ignores writes outside special modes
  ram_write_once_a: assert property (s_locked_ram_write |=> $stable(ram_pos)) // see R5
    else $error("locked ram position changed");

  // First write after reset always lands
  ram_first_write_a: assert property (
    once_wr[ONCE_RAM] && !once_lock[ONCE_RAM] |=> ram_pos == ($past(wb_dat_i[7:0]) & MMAP_RAM_MASK))
    else $error("first ram position write lost"); // see R5

  // In special modes a write changes the register the next cycle, not before
  ram_write_latency_a: assert property (
    s_special_ram_write |-> $stable(ram_pos) ##1 (ram_pos == ($past(wb_dat_i[7:0]) & MMAP_RAM_MASK)))
    else $error("ram position write latency wrong"); // see R6

  // A RAM select always matches the base field
  ram_base_match_a: assert property (
    sel_o.ram |-> core_req_i.addr[15:MMAP_WIN_LOG2] == ram_pos[7:MMAP_BASE_LSB])
    else $error("ram select outside base window"); // see R7

  // Low alignment keeps RAM at the bottom of the window
  ram_low_align_a: assert property (
    sel_o.ram && !ram_pos[MMAP_RAM_ALIGN_BIT] |-> core_req_i.addr[10:RAM_LOG2] == '0)
    else $error("low aligned ram hit in upper part"); // see R8

  // High alignment keeps RAM at the top of the window
  ram_high_align_a: assert property (
    sel_o.ram && ram_pos[MMAP_RAM_ALIGN_BIT] |-> &core_req_i.addr[10:RAM_LOG2])
    else $error("high aligned ram hit in lower part"); // see R9

  // External select tracks valid external accesses only
  ext_select_a: assert property (
    external_chip_select_n_o == !(core_req_i.valid && sel_o.external))
    else $error("external select mismatch"); // see R3

  // Emulation select is confined to emulation modes
  emu_select_a: assert property (!emulation_chip_select_n_o |-> mmap_is_emulation(mode_i))
    else $error("emulation select outside emulation mode"); // see R4

  // Unimplemented bits of the RAM position read as zero
  read_zero_bits_a: assert property (
    s_bus_req ##0 reg_hit(wb_adr_i, MMAP_RAM_POS_OFF) |=> wb_dat_o[31:8] == '0 && wb_dat_o[2:1] == 2'b00)
    else $error("unimplemented bits read nonzero"); // see R10

  // Unmapped offsets answer zero
  read_unmapped_a: assert property (
    s_bus_req ##0 (wb_adr_i > MMAP_PAGE_OFF) |=> wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero"); // see R10

endmodule : mmap_ctrl
`default_nettype wire

// file: mmap_pkg.sv
// Shared constants, types and mode helpers for the memory map control block
package mmap_pkg;

  // Register byte offsets on the Wishbone port, one aligned word each
  localparam logic [7:0] MMAP_RAM_POS_OFF = 8'h00;
  localparam logic [7:0] MMAP_REG_POS_OFF = 8'h04;
  localparam logic [7:0] MMAP_EE_POS_OFF = 8'h08;
  localparam logic [7:0] MMAP_AUX_OFF = 8'h0c;
  localparam logic [7:0] MMAP_TEST0_OFF = 8'h10;
  localparam logic [7:0] MMAP_SIZE_LO_OFF = 8'h14;
  localparam logic [7:0] MMAP_SIZE_HI_OFF = 8'h18;
  localparam logic [7:0] MMAP_PAGE_OFF = 8'h1c;

  // Field positions
  localparam int MMAP_BASE_LSB = 3;
  localparam int MMAP_RAM_ALIGN_BIT = 0;
  localparam int MMAP_EE_ON_BIT = 0;
  localparam int MMAP_AUX_STRETCH_LSB = 2;
  localparam int MMAP_AUX_ROMHM_BIT = 1;
  localparam int MMAP_AUX_ROMON_BIT = 0;
  localparam int MMAP_PAGE_W = 6;

  // Implemented bits of each writable register
  localparam logic [7:0] MMAP_RAM_MASK = 8'hf9;
  localparam logic [7:0] MMAP_REG_MASK = 8'h78;
  localparam logic [7:0] MMAP_EE_MASK = 8'hf9;
  localparam logic [7:0] MMAP_AUX_MASK = 8'h0f;
  localparam logic [7:0] MMAP_PAGE_MASK = 8'h3f;

  // Reset values
  localparam logic [7:0] MMAP_RAM_RST = 8'h09;
  localparam logic [7:0] MMAP_REG_RST = 8'h00;
  localparam logic [7:0] MMAP_EE_RST = 8'h00;
  localparam logic [7:0] MMAP_AUX_RST = 8'h0d;
  localparam logic [7:0] MMAP_AUX_RST_TEST = 8'h0c;
  localparam logic [7:0] MMAP_PAGE_RST = 8'h00;

  // Base fields select a 2K byte window
  localparam int MMAP_WIN_LOG2 = 11;

  // System operating modes
  typedef enum logic [2:0] {
    MMAP_SPECIAL_SINGLE,
    MMAP_EMU_NARROW,
    MMAP_SPECIAL_TEST,
    MMAP_EMU_WIDE,
    MMAP_NORMAL_SINGLE,
    MMAP_NORMAL_NARROW,
    MMAP_PERIPHERAL,
    MMAP_NORMAL_WIDE
  } mmap_mode_t;

  // Core access request
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } mmap_core_req_t;

  // Resource select, at most one bit set
  typedef struct packed {
    logic regs;
    logic ram;
    logic eeprom;
    logic flash;
    logic external;
  } mmap_sel_t;

  function automatic logic mmap_is_special(input mmap_mode_t m);
    return (m == MMAP_SPECIAL_SINGLE) || (m == MMAP_SPECIAL_TEST) || (m == MMAP_PERIPHERAL);
  endfunction : mmap_is_special

  function automatic logic mmap_is_emulation(input mmap_mode_t m);
    return (m == MMAP_EMU_NARROW) || (m == MMAP_EMU_WIDE);
  endfunction : mmap_is_emulation

  function automatic logic mmap_is_expanded(input mmap_mode_t m);
    return (m == MMAP_EMU_NARROW) || (m == MMAP_EMU_WIDE) || (m == MMAP_SPECIAL_TEST) ||
           (m == MMAP_NORMAL_NARROW) || (m == MMAP_NORMAL_WIDE);
  endfunction : mmap_is_expanded

endpackage : mmap_pkg

// file: mmap_once_reg.sv
// Mapping register that locks after its first write outside special modes
`timescale 1ns/100ps
`default_nettype none
module mmap_once_reg
  import mmap_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] rst_val_i,
  input wire logic wr_i,
  input wire logic special_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] q_o,
  output logic locked_o
);

  logic [7:0] q_r, q_nxt;
  logic lock_r, lock_nxt;

  // First write always lands; later ones only in special modes
  always_comb begin
    q_nxt = q_r;
    lock_nxt = lock_r;
    if (wr_i && (special_i || !lock_r)) begin // see R5
      q_nxt = dat_i & MASK; // see R10
      lock_nxt = 1'b1;
    end
  end

  // Reset value may depend on the mode, so it is loaded synchronously
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_r <= rst_val_i & MASK;
      lock_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign q_o = q_r;
  assign locked_o = lock_r;

endmodule : mmap_once_reg
`default_nettype wire

// file: mmap_decode.sv
// Combinational address decoder and chip select generation
`timescale 1ns/100ps
`default_nettype none
module mmap_decode
  import mmap_pkg::*;
#(
  parameter int RAM_LOG2 = 10,
  parameter int REG_LOG2 = 10,
  parameter int EE_LOG2 = 10
) (
  input wire mmap_core_req_t req_i,
  input wire mmap_mode_t mode_i,
  input wire logic [7:0] ram_pos_i,
  input wire logic [7:0] reg_pos_i,
  input wire logic [7:0] ee_pos_i,
  input wire logic [7:0] aux_i,
  input wire logic [7:0] page_i,
  output mmap_sel_t sel_o,
  output logic xcs_n_o,
  output logic ecs_n_o,
  output logic [19:0] page_addr_o
);

  localparam logic [10:0] RAM_UMASK = 11'(~((1 << RAM_LOG2) - 1));
  localparam logic [10:0] REG_UMASK = 11'(~((1 << REG_LOG2) - 1));
  localparam logic [10:0] EE_UMASK = 11'(~((1 << EE_LOG2) - 1));

  // Hit in a block placed low or high inside its 2K window
  function automatic logic in_block(input logic [15:0] a, input logic [4:0] base,
                                    input logic [10:0] umask, input logic high);
    logic [10:0] upper;
    upper = a[10:0] & umask;
    return (a[15:MMAP_WIN_LOG2] == base) && (upper == (high ? umask : 11'h000));
  endfunction : in_block

  logic hit_reg, hit_ram, hit_ee, flash_space, hit_flash;

  // Registers win over RAM, RAM over EEPROM, EEPROM over flash
  always_comb begin
    hit_reg = in_block(req_i.addr, {1'b0, reg_pos_i[6:MMAP_BASE_LSB]}, REG_UMASK, 1'b0);
    hit_ram = in_block(req_i.addr, ram_pos_i[7:MMAP_BASE_LSB], RAM_UMASK,
                       ram_pos_i[MMAP_RAM_ALIGN_BIT]); // see R7 see R8 see R9
    hit_ee = ee_pos_i[MMAP_EE_ON_BIT] &&
             in_block(req_i.addr, ee_pos_i[7:MMAP_BASE_LSB], EE_UMASK, 1'b0);
    flash_space = (req_i.addr[15:14] != 2'b00) &&
                  !(aux_i[MMAP_AUX_ROMHM_BIT] && (req_i.addr[15:14] == 2'b01));
    hit_flash = aux_i[MMAP_AUX_ROMON_BIT] && flash_space;
    sel_o.regs = hit_reg; // see R2
    sel_o.ram = hit_ram && !hit_reg;
    sel_o.eeprom = hit_ee && !hit_ram && !hit_reg;
    sel_o.flash = hit_flash && !hit_ee && !hit_ram && !hit_reg;
    sel_o.external = mmap_is_expanded(mode_i) && !(hit_flash || hit_ee || hit_ram || hit_reg);
  end

  // Strobes are gated by a valid access so idle cycles select nothing
  assign xcs_n_o = !(req_i.valid && sel_o.external); // see R3
  assign ecs_n_o = !(req_i.valid && mmap_is_emulation(mode_i) && flash_space); // see R4

  // Paged window at 0x8000 carries the page index into the expanded address
  assign page_addr_o = (req_i.addr[15:14] == 2'b10) ?
                       {page_i[MMAP_PAGE_W-1:0], req_i.addr[13:0]} : {4'h0, req_i.addr};

endmodule : mmap_decode
`default_nettype wire

// file: mmap_core_model.sv
// Behavioural model of the core side that issues accesses to the map decoder
`timescale 1ns/100ps
`default_nettype none
module mmap_core_model
  import mmap_pkg::*;
(
  input wire logic clk_i,
  output var mmap_core_req_t req_o
);
  // Idle bus shows no stale address: the inverse of the last one is left behind
  initial begin
    req_o = '0;
  end

  // Present one access just after a rising edge and hold it until released
  task automatic access(input logic [15:0] addr);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, addr: addr};
  endtask : access

  // Release the bus; the address no longer carries the last value
  task automatic release_bus();
    @(posedge clk_i);
    req_o <= '{valid: 1'b0, addr: ~req_o.addr};
  endtask : release_bus
endmodule : mmap_core_model
`default_nettype wire

// file: memory_map_control_test.sv
// Self-checking testbench for the memory map control block
`timescale 1ns/100ps
`default_nettype none
module memory_map_control_test
  import mmap_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  mmap_mode_t mode_i = MMAP_NORMAL_SINGLE;
  mmap_core_req_t core_req_i;
  mmap_sel_t sel_o;
  logic xcs_n;
  logic ecs_n;
  logic [1:0] stretch;
  logic [19:0] paddr;
  logic [31:0] rd;
  logic [4:0] sel_at_ack;
  int miscompares = 0;
  int cmp_count = 0;
  int i;
  logic [7:0] offs [4] = '{8'h04, 8'h08, 8'h0c, 8'h1c};
  logic [7:0] msks [4] = '{8'h78, 8'hf9, 8'h0f, 8'h3f};

  mmap_ctrl u_mmap_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mode_i(mode_i), .core_req_i(core_req_i), .sel_o(sel_o),
    .external_chip_select_n_o(xcs_n), .emulation_chip_select_n_o(ecs_n), .stretch_o(stretch), .page_addr_o(paddr)
  );

  mmap_core_model u_mmap_core_model (.clk_i(clk_i), .req_o(core_req_i));

  // Clock at 100 MHz
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One classic cycle; the decode seen while ack is up is kept for latency checks
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, dat};
    n = 0;
    // Ack and read data are taken at the very rising edge that samples ack high
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      finish_test();
    end
    rd = wb_dat_o;
    sel_at_ack = sel_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(negedge clk_i);
  endtask : wb_cycle

  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    wb_cycle(1'b0, adr, 8'h00);
    check("register read", rd, {24'h0, exp});
  endtask : rd_chk

  // Core access checked for the resource select and both chip selects
  task automatic probe(input logic [15:0] a, input logic [4:0] s, input logic x, input logic e);
    u_mmap_core_model.access(a);
    @(negedge clk_i);
    check("resource select", {27'h0, sel_o}, {27'h0, s});
    check("external select", {31'h0, xcs_n}, {31'h0, x});
    check("emulation select", {31'h0, ecs_n}, {31'h0, e});
  endtask : probe

  // Mode is only changed around a reset since the design takes it as steady
  task automatic do_reset(input mmap_mode_t m);
    @(posedge clk_i);
    mode_i <= m;
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial begin
    do_reset(MMAP_NORMAL_SINGLE);
    rd_chk(8'h00, 8'h09);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h0c, 8'h0d);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h20, 8'h00);
    probe(16'h2000, 5'b00000, 1'b1, 1'b1);
    // Old placement must govern the write cycle itself, the new one from the next
    probe(16'hfc00, 5'b00010, 1'b1, 1'b1);
    wb_cycle(1'b1, 8'h00, 8'hff);
    check("decode during write", {27'h0, sel_at_ack}, 32'h2);
    check("decode after write", {27'h0, sel_o}, 32'h8);
    rd_chk(8'h00, 8'hf9);
    wb_cycle(1'b1, 8'h00, 8'h10);
    rd_chk(8'h00, 8'hf9);
    probe(16'hfbff, 5'b00010, 1'b1, 1'b1);
    // Masked bits of the other writable registers
    for (i = 0; i < 4; i++) begin
      wb_cycle(1'b1, offs[i], 8'hff);
      rd_chk(offs[i], msks[i]);
    end
    // Enabled EEPROM under the RAM, flash hidden low, page index in the wide address
    probe(16'hf800, 5'b00100, 1'b1, 1'b1);
    probe(16'h4000, 5'b00000, 1'b1, 1'b1);
    probe(16'h8123, 5'b00010, 1'b1, 1'b1);
    check("paged address", {12'h0, paddr}, 32'h000fc123);
    do_reset(MMAP_SPECIAL_SINGLE);
    wb_cycle(1'b1, 8'h00, 8'h10);
    rd_chk(8'h00, 8'h10);
    probe(16'h1000, 5'b01000, 1'b1, 1'b1);
    probe(16'h1400, 5'b00000, 1'b1, 1'b1);
    wb_cycle(1'b1, 8'h00, 8'h11);
    rd_chk(8'h00, 8'h11);
    probe(16'h1400, 5'b01000, 1'b1, 1'b1);
    probe(16'h13ff, 5'b00000, 1'b1, 1'b1);
    // Stretch field and flash disable, upper bits masked off
    wb_cycle(1'b1, 8'h0c, 8'hf4);
    check("stretch", {30'h0, stretch}, 32'h1);
    probe(16'hc000, 5'b00000, 1'b1, 1'b1);
    do_reset(MMAP_SPECIAL_TEST);
    rd_chk(8'h0c, 8'h0c);
    do_reset(MMAP_NORMAL_WIDE);
    probe(16'h2000, 5'b00001, 1'b0, 1'b1);
    probe(16'h0c00, 5'b01000, 1'b1, 1'b1);
    probe(16'hc000, 5'b00010, 1'b1, 1'b1);
    do_reset(MMAP_EMU_WIDE);
    probe(16'hc000, 5'b00010, 1'b1, 1'b0);
    probe(16'h2000, 5'b00001, 1'b0, 1'b1);
    u_mmap_core_model.release_bus();
    wb_cycle(1'b1, 8'h00, 8'h21);
    wb_cycle(1'b1, 8'h00, 8'h30);
    rd_chk(8'h00, 8'h21);
    // Remaining modes: narrow emulation, narrow expanded and peripheral
    do_reset(MMAP_EMU_NARROW);
    probe(16'hc000, 5'b00010, 1'b1, 1'b0);
    do_reset(MMAP_NORMAL_NARROW);
    probe(16'h2000, 5'b00001, 1'b0, 1'b1);
    do_reset(MMAP_PERIPHERAL);
    wb_cycle(1'b1, 8'h00, 8'h21);
    wb_cycle(1'b1, 8'h00, 8'h30);
    rd_chk(8'h00, 8'h30);
    finish_test();
  end
endmodule : memory_map_control_test
`default_nettype wire
